// *** design/mcam_config_bank.sv ***
// Purpose: configuration and alert mask register bank of the hardware monitor
// Assumes: register port comes from the serial-bus engine on MCLK
// Notes:   the lock, channel select, test bit and pin-mode bit live elsewhere
//
// Behaviour
// - The second remote temperature offset at 0x72 is read/write, resets to 0x00 and is added to that reading.
// - The offset is two's complement with one lsb per degree, so it can raise or lower the reading.
// - Once the lock bit is 1 the offset register ignores writes and stays readable.
// - The configuration register at 0x73 resets to 0x00 so every feature starts cleared.
// - Config bits 0 to 3 choose per fan between pulse input (0) and sense-resistor measurement (1).
// - Config bit 4 switches to the faster conversion averaging.
// - Config bit 5 bypasses the input dividers on the 2.5 V, core, 5 V and 12 V inputs.
// - Config bit 6 makes the converter run continuously on the channel given by bits 7:5 of 0x55.
// - In single-channel mode, with test bit 2 of 0x7F set, rising edges on the first fan pin start conversions.
// - Config bit 7 is reserved but reads back what was written.
// - The first alert mask at 0x74 resets to 0x00 so nothing is masked.
// - Mask bits 0 to 3 stop alerts from the 2.5 V, core, device supply and 5 V channels.
// - Mask bits 4 to 6 stop alerts from the first remote, local and second remote temperatures.
// - Mask bit 7 lets the second mask register act; while it is 0 those bits are ignored.
// - The second mask at 0x75 holds masks for 12 V, overtemperature, four fans and two diodes.
// - The shared fan-drive pin carries the alert only while bit 0 of 0x78 is 1.
`timescale 1ns/100ps
module mcam_config_bank #(
    parameter int REG_W = mcam_pkg::REG_W
) (
    // clock, reset, enable
    input  wire logic                                MCLK,
    input  wire logic                                RST,
    input  wire logic                                CE,
    // register port
    input  wire logic [7:0]                          REG_ADDR,
    input  wire logic                                REG_WR,
    input  wire logic [REG_W-1:0]                    REG_WDATA,
    input  wire logic                                REG_RD,
    output logic      [REG_W-1:0]                    REG_RDATA,
    output logic                                     REG_RVALID,
    // settings held elsewhere
    input  wire logic                                CFG_LOCK,
    input  wire logic [mcam_pkg::CHAN_SEL_W-1:0]     CHAN_SEL_IN,
    input  wire logic                                EXT_SINGLE_CHANNEL_SELECT_ENABLE,
    input  wire logic                                ALERT_PIN_SELECT,
    // second remote temperature
    input  wire logic [REG_W-1:0]                    REMOTE_TWO_RAW,
    input  wire logic                                REMOTE_TWO_RAW_VALID,
    output logic      [REG_W-1:0]                    REMOTE_TWO_ADJ,
    output logic                                     REMOTE_TWO_ADJ_VALID,
    // measurement controls
    output logic      [mcam_pkg::FAN_COUNT-1:0]      FAN_SENSE_MODE,
    output logic                                     CONVERSION_SMOOTHING,
    output logic                                     INPUT_DIVIDER_BYPASS,
    output logic                                     SINGLE_CHANNEL_MODE,
    output logic      [mcam_pkg::CHAN_SEL_W-1:0]     SINGLE_CHANNEL_CHAN,
    // external conversion start
    input  wire logic                                FAN1_SENSE_PIN,
    output logic                                     EXT_SINGLE_CHANNEL_SELECT_START,
    // out-of-limit events
    input  wire logic [mcam_pkg::EVENTS_ONE_W-1:0]   EVENTS_ONE,
    input  wire logic [mcam_pkg::EVENTS_TWO_W-1:0]   EVENTS_TWO,
    output logic                                     ALERT,
    // shared fan-drive / alert pin
    input  wire logic                                FAN2_DRIVE,
    output logic                                     SHARED_PIN_O,
    output logic                                     SHARED_PIN_OE
);

    logic [REG_W-1:0] remote_two_temp_offset_reg;
    logic [REG_W-1:0] measurement_config_two_reg;
    logic [REG_W-1:0] alert_mask_one_reg;
    logic [REG_W-1:0] alert_mask_two_reg;

    logic [REG_W-1:0] rdata_next;
    logic             rmapped_next;
    logic [REG_W-1:0] adj_next;
    logic             alert_next;

    logic             sense_meta_reg;
    logic             sense_sync_reg;
    logic             sense_prev_reg;

    logic             wr_offset;
    logic             wr_config;
    logic             wr_mask_one;
    logic             wr_mask_two;

    assign wr_offset   = REG_WR && (REG_ADDR == mcam_pkg::OFS_REMOTE_TWO_TEMP_OFFSET);
    assign wr_config   = REG_WR && (REG_ADDR == mcam_pkg::OFS_MEASUREMENT_CONFIG_TWO);
    assign wr_mask_one = REG_WR && (REG_ADDR == mcam_pkg::OFS_ALERT_MASK_ONE);
    assign wr_mask_two = REG_WR && (REG_ADDR == mcam_pkg::OFS_ALERT_MASK_TWO);

    // offset register
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            remote_two_temp_offset_reg <= mcam_pkg::RST_REMOTE_TWO_TEMP_OFFSET;
        end else if (CE) begin
            if (wr_offset && !CFG_LOCK) begin
                remote_two_temp_offset_reg <= REG_WDATA;
            end
        end
    end

    // configuration register; reserved bit 7 is stored like the rest
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            measurement_config_two_reg <= mcam_pkg::RST_MEASUREMENT_CONFIG_TWO;
        end else if (CE) begin
            if (wr_config) begin
                measurement_config_two_reg <= REG_WDATA;
            end
        end
    end

    // first mask register
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            alert_mask_one_reg <= mcam_pkg::RST_ALERT_MASK_ONE;
        end else if (CE) begin
            if (wr_mask_one) begin
                alert_mask_one_reg <= REG_WDATA;
            end
        end
    end

    // second mask register; only acts while the gate bit is set
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            alert_mask_two_reg <= mcam_pkg::RST_ALERT_MASK_TWO;
        end else if (CE) begin
            if (wr_mask_two) begin
                alert_mask_two_reg <= REG_WDATA;
            end
        end
    end

    // read mux
    always_comb begin
        rdata_next   = mcam_pkg::UNMAPPED_READ_VALUE;
        rmapped_next = 1'b1;
        unique case (REG_ADDR)
            mcam_pkg::OFS_REMOTE_TWO_TEMP_OFFSET: begin
                rdata_next = remote_two_temp_offset_reg;
            end
            mcam_pkg::OFS_MEASUREMENT_CONFIG_TWO: begin
                rdata_next = measurement_config_two_reg;
            end
            mcam_pkg::OFS_ALERT_MASK_ONE: begin
                rdata_next = alert_mask_one_reg;
            end
            mcam_pkg::OFS_ALERT_MASK_TWO: begin
                rdata_next = alert_mask_two_reg;
            end
            default: begin
                rmapped_next = 1'b0;
            end
        endcase
    end

    // read answer valid follows the strobe one cycle later, for as many cycles as the strobe lasts
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REG_RVALID <= 1'b0;
        end else if (CE) begin
            REG_RVALID <= REG_RD;
        end
    end

    // read data holds until the next read, every offset answers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= mcam_pkg::UNMAPPED_READ_VALUE;
        end else if (CE) begin
            if (REG_RD) begin
                REG_RDATA <= rmapped_next ? rdata_next : mcam_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    mcam_offset_adder #(
        .W        (REG_W)
    ) u_offset_adder (
        .reading  (REMOTE_TWO_RAW),
        .offset   (remote_two_temp_offset_reg),
        .adjusted (adj_next)
    );

    // adjusted reading valid, one cycle behind the raw strobe
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REMOTE_TWO_ADJ_VALID <= 1'b0;
        end else if (CE) begin
            REMOTE_TWO_ADJ_VALID <= REMOTE_TWO_RAW_VALID;
        end
    end

    // adjusted reading, held between samples
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REMOTE_TWO_ADJ <= '0;
        end else if (CE) begin
            if (REMOTE_TWO_RAW_VALID) begin
                REMOTE_TWO_ADJ <= adj_next;
            end
        end
    end

    // measurement control outputs, one cycle behind the register and CHAN_SEL_IN
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            FAN_SENSE_MODE       <= '0;
            CONVERSION_SMOOTHING <= 1'b0;
            INPUT_DIVIDER_BYPASS <= 1'b0;
            SINGLE_CHANNEL_MODE  <= 1'b0;
            SINGLE_CHANNEL_CHAN  <= '0;
        end else if (CE) begin
            FAN_SENSE_MODE <= measurement_config_two_reg[mcam_pkg::CFG_FAN_SENSE_MSB:
                                                         mcam_pkg::CFG_FAN_SENSE_LSB];
            CONVERSION_SMOOTHING <=
                measurement_config_two_reg[mcam_pkg::CFG_CONVERSION_SMOOTHING];
            INPUT_DIVIDER_BYPASS <=
                measurement_config_two_reg[mcam_pkg::CFG_INPUT_DIVIDER_BYPASS];
            SINGLE_CHANNEL_MODE <=
                measurement_config_two_reg[mcam_pkg::CFG_SINGLE_CHANNEL_SELECT];
            SINGLE_CHANNEL_CHAN <= CHAN_SEL_IN;
        end
    end

    // fan pin is asynchronous; only the second and third stages are read
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sense_meta_reg <= 1'b0;
            sense_sync_reg <= 1'b0;
            sense_prev_reg <= 1'b0;
        end else if (CE) begin
            sense_meta_reg <= FAN1_SENSE_PIN;
            sense_sync_reg <= sense_meta_reg;
            sense_prev_reg <= sense_sync_reg;
        end
    end

    // conversion start on each rising edge of the first fan pin, only while enabled and in single-channel mode
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            EXT_SINGLE_CHANNEL_SELECT_START <= 1'b0;
        end else if (CE) begin
            EXT_SINGLE_CHANNEL_SELECT_START <= sense_sync_reg && !sense_prev_reg && EXT_SINGLE_CHANNEL_SELECT_ENABLE &&
                              measurement_config_two_reg[mcam_pkg::CFG_SINGLE_CHANNEL_SELECT];
        end
    end

    mcam_alert_mask #(
        .N1            (mcam_pkg::EVENTS_ONE_W),
        .N2            (mcam_pkg::EVENTS_TWO_W)
    ) u_alert_mask (
        .events_one    (EVENTS_ONE),
        .events_two    (EVENTS_TWO),
        .mask_one      (alert_mask_one_reg[mcam_pkg::MASK1_REMOTE_TWO_TEMP:
                                           mcam_pkg::MASK1_VOLT_LSB]),
        .mask_two_gate (alert_mask_one_reg[mcam_pkg::MASK1_MASK_TWO_GATE]),
        .mask_two      (alert_mask_two_reg),
        .alert_any     (alert_next)
    );

    // alert level
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ALERT <= 1'b0;
        end else if (CE) begin
            ALERT <= alert_next;
        end
    end

    // shared pin; floats during reset
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SHARED_PIN_O  <= 1'b0;
            SHARED_PIN_OE <= 1'b0;
        end else if (CE) begin
            if (ALERT_PIN_SELECT) begin
                // open-drain, active low: drive low only while alerting
                SHARED_PIN_O  <= 1'b0;
                SHARED_PIN_OE <= alert_next;
            end else begin
                SHARED_PIN_O  <= FAN2_DRIVE;
                SHARED_PIN_OE <= 1'b1;
            end
        end
    end

endmodule : mcam_config_bank

// *** design/mcam_pkg.sv ***
// Purpose: shared constants for the monitor configuration and alert mask bank
// Assumes: 8-bit register port driven by the serial-bus engine on MCLK
// Notes:   offsets are the register addresses seen by the serial-bus host
package mcam_pkg;

    // register offsets
    localparam logic [7:0] OFS_REMOTE_TWO_TEMP_OFFSET = 8'h72;
    localparam logic [7:0] OFS_MEASUREMENT_CONFIG_TWO = 8'h73;
    localparam logic [7:0] OFS_ALERT_MASK_ONE         = 8'h74;
    localparam logic [7:0] OFS_ALERT_MASK_TWO         = 8'h75;

    // values after reset
    localparam logic [7:0] RST_REMOTE_TWO_TEMP_OFFSET = 8'h00;
    localparam logic [7:0] RST_MEASUREMENT_CONFIG_TWO = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK_ONE         = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK_TWO         = 8'h00;

    // value read back from an unmapped offset
    localparam logic [7:0] UNMAPPED_READ_VALUE        = 8'h00;

    // measurement_config_two field positions
    localparam int CFG_FAN_SENSE_LSB          = 0;
    localparam int CFG_FAN_SENSE_MSB          = 3;
    localparam int CFG_CONVERSION_SMOOTHING   = 4;
    localparam int CFG_INPUT_DIVIDER_BYPASS   = 5;
    localparam int CFG_SINGLE_CHANNEL_SELECT  = 6;
    localparam int CFG_RESERVED               = 7;

    // alert_mask_one field positions
    localparam int MASK1_VOLT_LSB             = 0;
    localparam int MASK1_VOLT_MSB             = 3;
    localparam int MASK1_REMOTE_ONE_TEMP      = 4;
    localparam int MASK1_LOCAL_TEMP           = 5;
    localparam int MASK1_REMOTE_TWO_TEMP      = 6;
    localparam int MASK1_MASK_TWO_GATE        = 7;

    // alert_mask_two field positions
    localparam int MASK2_TWELVE_VOLT          = 0;
    localparam int MASK2_OVER_TEMP            = 1;
    localparam int MASK2_FAN_LSB              = 2;
    localparam int MASK2_FAN_MSB              = 5;
    localparam int MASK2_DIODE_ONE            = 6;
    localparam int MASK2_DIODE_TWO            = 7;

    // widths
    localparam int REG_W        = 8;
    localparam int EVENTS_ONE_W = 7;
    localparam int EVENTS_TWO_W = 8;
    localparam int FAN_COUNT    = 4;
    localparam int CHAN_SEL_W   = 3;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES  = 2;

endpackage : mcam_pkg

// *** design/mcam_offset_adder.sv ***
// Purpose: adds a signed offset to a signed temperature reading
// Assumes: both operands two's complement, one lsb per degree
// Notes:   result clamps at the ends of the signed range instead of wrapping
`timescale 1ns/100ps
module mcam_offset_adder #(
    parameter int W = 8
) (
    // operands
    input  wire logic [W-1:0] reading,
    input  wire logic [W-1:0] offset,
    // result
    output logic      [W-1:0] adjusted
);

    logic [W:0] sum_wide;

    // a wrap from +127 to -128 would look like a sudden freeze alarm
    always_comb begin
        sum_wide = {reading[W-1], reading} + {offset[W-1], offset};
        if (sum_wide[W] != sum_wide[W-1]) begin
            adjusted = {sum_wide[W], {(W-1){~sum_wide[W]}}};
        end else begin
            adjusted = sum_wide[W-1:0];
        end
    end

endmodule : mcam_offset_adder

// *** design/mcam_alert_mask.sv ***
// Purpose: combines out-of-limit events with both mask registers
// Assumes: event inputs are levels, high while the condition holds
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
module mcam_alert_mask #(
    parameter int N1 = 7,
    parameter int N2 = 8
) (
    // event levels
    input  wire logic [N1-1:0] events_one,
    input  wire logic [N2-1:0] events_two,
    // masks
    input  wire logic [N1-1:0] mask_one,
    input  wire logic          mask_two_gate,
    input  wire logic [N2-1:0] mask_two,
    // result
    output logic               alert_any
);

    logic [N1-1:0] pass_one;
    logic [N2-1:0] pass_two;

    genvar gi;
    generate
        for (gi = 0; gi < N1; gi++) begin : g_one
            assign pass_one[gi] = events_one[gi] & ~mask_one[gi];
        end
        for (gi = 0; gi < N2; gi++) begin : g_two
            assign pass_two[gi] = events_two[gi] & ~(mask_two[gi] & mask_two_gate);
        end
    endgenerate

    assign alert_any = (|pass_one) | (|pass_two);

endmodule : mcam_alert_mask

// *** bench/mcam_config_bank_sva.sv ***
// Purpose: port-level checks for the config and alert mask bank
// Assumes: single MCLK domain, RST async active high
// Notes:   mask registers are shadowed from writes to predict the alert
`timescale 1ns/100ps
module mcam_config_bank_sva (
    // clock and reset
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       CE,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_RD,
    input wire logic       REG_RVALID,
    // settings held elsewhere
    input wire logic [2:0] CHAN_SEL_IN,
    input wire logic       EXT_SINGLE_CHANNEL_SELECT_ENABLE,
    input wire logic       ALERT_PIN_SELECT,
    // reading path and controls
    input wire logic       REMOTE_TWO_RAW_VALID,
    input wire logic       REMOTE_TWO_ADJ_VALID,
    input wire logic [3:0] FAN_SENSE_MODE,
    input wire logic       CONVERSION_SMOOTHING,
    input wire logic       INPUT_DIVIDER_BYPASS,
    input wire logic       SINGLE_CHANNEL_MODE,
    input wire logic [2:0] SINGLE_CHANNEL_CHAN,
    input wire logic       FAN1_SENSE_PIN,
    input wire logic       EXT_SINGLE_CHANNEL_SELECT_START,
    // alert and shared pin
    input wire logic [6:0] EVENTS_ONE,
    input wire logic [7:0] EVENTS_TWO,
    input wire logic       ALERT,
    input wire logic       FAN2_DRIVE,
    input wire logic       SHARED_PIN_O,
    input wire logic       SHARED_PIN_OE
);
    logic [7:0] mask_one_reg;
    logic [7:0] mask_two_reg;
    logic       alert_want;

    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mask_one_reg <= 8'h00;
            mask_two_reg <= 8'h00;
        end else if (CE && REG_WR) begin
            if (REG_ADDR == 8'h74) mask_one_reg <= REG_WDATA;
            if (REG_ADDR == 8'h75) mask_two_reg <= REG_WDATA;
        end
    end

    // second mask only counts while the gate bit is set
    assign alert_want = (|(EVENTS_ONE & ~mask_one_reg[6:0]))
                      | (|(EVENTS_TWO & ~(mask_one_reg[7] ? mask_two_reg : 8'h00)));

    read_answer_a: assert property (
        !$past(RST) |-> REG_RVALID == $past(CE && REG_RD)) else $error("read answer out of step");
    adj_valid_a: assert property (
        !$past(RST) |-> REMOTE_TWO_ADJ_VALID == $past(CE && REMOTE_TWO_RAW_VALID))
        else $error("adjusted valid out of step");
    fan_mode_a: assert property (
        CE && REG_WR && REG_ADDR == 8'h73 |-> ##2 FAN_SENSE_MODE == $past(REG_WDATA[3:0], 2))
        else $error("fan sense mode not taken from config");
    ctrl_bits_a: assert property (
        CE && REG_WR && REG_ADDR == 8'h73 |-> ##2
        {SINGLE_CHANNEL_MODE, INPUT_DIVIDER_BYPASS, CONVERSION_SMOOTHING}
        == $past(REG_WDATA[6:4], 2)) else $error("config control bits wrong");
    chan_copy_a: assert property (
        !$past(RST) |-> SINGLE_CHANNEL_CHAN == $past(CHAN_SEL_IN)) else $error("channel copy wrong");
    alert_mask_a: assert property (
        !$past(RST) |-> ALERT == $past(alert_want)) else $error("alert disagrees with masks");
    pin_enable_a: assert property (
        !$past(RST) |-> SHARED_PIN_OE == ($past(ALERT_PIN_SELECT) ? ALERT : 1'b1))
        else $error("shared pin enable wrong");
    pin_level_a: assert property (
        !$past(RST) |-> SHARED_PIN_O == ($past(ALERT_PIN_SELECT) ? 1'b0 : $past(FAN2_DRIVE)))
        else $error("shared pin level wrong");
    ext_start_a: assert property (
        $rose(FAN1_SENSE_PIN) && SINGLE_CHANNEL_MODE && EXT_SINGLE_CHANNEL_SELECT_ENABLE |-> ##[2:5] EXT_SINGLE_CHANNEL_SELECT_START)
        else $error("external start missing");
    start_pulse_a: assert property (
        EXT_SINGLE_CHANNEL_SELECT_START |=> !EXT_SINGLE_CHANNEL_SELECT_START) else $error("external start longer than one cycle");
    start_gate_a: assert property (
        EXT_SINGLE_CHANNEL_SELECT_START |-> $past(EXT_SINGLE_CHANNEL_SELECT_ENABLE) && SINGLE_CHANNEL_MODE)
        else $error("external start while not enabled");

    cover property (ALERT && SHARED_PIN_OE && ALERT_PIN_SELECT);
    cover property (EXT_SINGLE_CHANNEL_SELECT_START);
    cover property (REMOTE_TWO_ADJ_VALID);
endmodule : mcam_config_bank_sva

bind mcam_config_bank mcam_config_bank_sva mcam_config_bank_sva_i (
    .MCLK(MCLK), .RST(RST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RVALID(REG_RVALID),
    .CHAN_SEL_IN(CHAN_SEL_IN), .EXT_SINGLE_CHANNEL_SELECT_ENABLE(EXT_SINGLE_CHANNEL_SELECT_ENABLE),
    .ALERT_PIN_SELECT(ALERT_PIN_SELECT), .REMOTE_TWO_RAW_VALID(REMOTE_TWO_RAW_VALID),
    .REMOTE_TWO_ADJ_VALID(REMOTE_TWO_ADJ_VALID), .FAN_SENSE_MODE(FAN_SENSE_MODE),
    .CONVERSION_SMOOTHING(CONVERSION_SMOOTHING), .INPUT_DIVIDER_BYPASS(INPUT_DIVIDER_BYPASS),
    .SINGLE_CHANNEL_MODE(SINGLE_CHANNEL_MODE), .SINGLE_CHANNEL_CHAN(SINGLE_CHANNEL_CHAN),
    .FAN1_SENSE_PIN(FAN1_SENSE_PIN), .EXT_SINGLE_CHANNEL_SELECT_START(EXT_SINGLE_CHANNEL_SELECT_START),
    .EVENTS_ONE(EVENTS_ONE), .EVENTS_TWO(EVENTS_TWO), .ALERT(ALERT), .FAN2_DRIVE(FAN2_DRIVE),
    .SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE(SHARED_PIN_OE));

// *** bench/mcam_host_model.sv ***
// Purpose: serial-bus host stand-in driving the byte register port
// Assumes: requests launched 1 ns after a rising MCLK edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/100ps
module mcam_host_model (
    // clock
    input  wire logic       mclk,
    // request
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    // answer
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // answer is registered, so it stands just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
        ok       = reg_rvalid;
    endtask : rd
endmodule : mcam_host_model

// *** bench/tb_monitor_config_alert_mask.sv ***
// Purpose: self-checking bench for the config and alert mask bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   each row writes a register, applies events, checks alert and readback
`timescale 1ns/100ps
module tb_monitor_config_alert_mask;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [6:0] ev1;
        logic [7:0] ev2;
        logic       alert;
    } mcam_row_t;

    logic       mclk, rst, wr, rd, rvalid, adj_valid, smooth, bypass, sc_mode, start;
    logic       alert, pin_o, pin_oe, ok;
    logic       lock = 1'b0, ext_en = 1'b0, pin_sel = 1'b0, raw_valid = 1'b0;
    logic       fan1_pin = 1'b0, fan2_drive = 1'b0, ce = 1'b1;
    logic [7:0] addr, wdata, rdata, adj, rd_val;
    logic [7:0] raw = 8'h00, evt_two = 8'h00;
    logic [6:0] evt_one = 7'h00;
    logic [3:0] fan_mode;
    logic [2:0] chan_in = 3'h0, chan_out;
    int         bad_count, checks, cycles, n;
    mcam_row_t  rows [13] = '{
        '{8'h72, 8'ha5, 8'ha5, 7'h00, 8'h00, 1'b0}, '{8'h73, 8'h80, 8'h80, 7'h00, 8'h00, 1'b0},
        '{8'h7a, 8'h33, 8'h00, 7'h00, 8'h00, 1'b0}, '{8'h75, 8'hff, 8'hff, 7'h00, 8'h00, 1'b0},
        '{8'h74, 8'h00, 8'h00, 7'h01, 8'h00, 1'b1}, '{8'h74, 8'h01, 8'h01, 7'h01, 8'h00, 1'b0},
        '{8'h74, 8'h08, 8'h08, 7'h08, 8'h00, 1'b0}, '{8'h74, 8'h00, 8'h00, 7'h40, 8'h00, 1'b1},
        '{8'h74, 8'h60, 8'h60, 7'h60, 8'h00, 1'b0}, '{8'h74, 8'h41, 8'h41, 7'h00, 8'h01, 1'b1},
        '{8'h74, 8'hc1, 8'hc1, 7'h00, 8'h01, 1'b0}, '{8'h74, 8'hc1, 8'hc1, 7'h00, 8'h80, 1'b0},
        '{8'h74, 8'hc1, 8'hc1, 7'h10, 8'h80, 1'b1}};

    mcam_config_bank mcam_config_bank_i (
        .MCLK(mclk), .RST(rst), .CE(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .CFG_LOCK(lock),
        .CHAN_SEL_IN(chan_in), .EXT_SINGLE_CHANNEL_SELECT_ENABLE(ext_en), .ALERT_PIN_SELECT(pin_sel),
        .REMOTE_TWO_RAW(raw), .REMOTE_TWO_RAW_VALID(raw_valid), .REMOTE_TWO_ADJ(adj),
        .REMOTE_TWO_ADJ_VALID(adj_valid), .FAN_SENSE_MODE(fan_mode),
        .CONVERSION_SMOOTHING(smooth), .INPUT_DIVIDER_BYPASS(bypass),
        .SINGLE_CHANNEL_MODE(sc_mode), .SINGLE_CHANNEL_CHAN(chan_out),
        .FAN1_SENSE_PIN(fan1_pin), .EXT_SINGLE_CHANNEL_SELECT_START(start), .EVENTS_ONE(evt_one),
        .EVENTS_TWO(evt_two), .ALERT(alert), .FAN2_DRIVE(fan2_drive),
        .SHARED_PIN_O(pin_o), .SHARED_PIN_OE(pin_oe));

    mcam_host_model mcam_host_model_i (
        .mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata), .reg_rvalid(rvalid));

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        mcam_host_model_i.rd(a, rd_val, ok);
        chk("read valid", {7'h00, ok}, 8'h01);
        chk(nm, rd_val, exp);
    endtask : rd_chk

    task automatic end_sim;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // cut a hang short well beyond the expected run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 4; i++)
            rd_chk("reset value", 8'(8'h72 + i), 8'h00);
        for (int i = 0; i < 13; i++) begin
            mcam_host_model_i.wr(rows[i].addr, rows[i].wdata);
            evt_one = rows[i].ev1;
            evt_two = rows[i].ev2;
            tick(2);
            chk("alert", {7'h00, alert}, {7'h00, rows[i].alert});
            rd_chk("readback", rows[i].addr, rows[i].rdata);
        end
        pin_sel = 1'b1;
        tick(2);
        chk("pin alert", {6'h00, pin_o, pin_oe}, 8'h01);
        evt_one = 7'h00;
        tick(2);
        chk("pin quiet", {6'h00, pin_o, pin_oe}, 8'h00);
        pin_sel = 1'b0;
        fan2_drive = 1'b1;
        tick(2);
        chk("pin drive", {6'h00, pin_o, pin_oe}, 8'h03);
        mcam_host_model_i.wr(8'h72, 8'hfe);
        raw = 8'h10;
        raw_valid = 1'b1;
        tick(1);
        raw_valid = 1'b0;
        chk("adj valid", {7'h00, adj_valid}, 8'h01);
        chk("adjusted", adj, 8'h0e);
        lock = 1'b1;
        mcam_host_model_i.wr(8'h72, 8'h33);
        rd_chk("locked offset", 8'h72, 8'hfe);
        raw = 8'h81;
        raw_valid = 1'b1;
        tick(1);
        raw_valid = 1'b0;
        chk("clamped", adj, 8'h80);
        lock = 1'b0;
        mcam_host_model_i.wr(8'h73, 8'hcf);
        tick(1);
        chk("config out", {1'b0, sc_mode, bypass, smooth, fan_mode}, 8'h4f);
        chan_in = 3'h5;
        tick(2);
        chk("channel", {5'h00, chan_out}, 8'h05);
        for (int e = 1; e >= 0; e--) begin
            ext_en = e[0];
            fan1_pin = 1'b1;
            n = 0;
            repeat (8) begin
                tick(1);
                n += int'(start === 1'b1);
            end
            chk("start pulses", 8'(n), 8'(e));
            fan1_pin = 1'b0;
            tick(4);
        end
        mcam_host_model_i.wr(8'h73, 8'hb0);
        tick(1);
        chk("config out", {1'b0, sc_mode, bypass, smooth, fan_mode}, 8'h30);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rd_chk("reset mask", 8'h74, 8'h00);
        rd_chk("reset config", 8'h73, 8'h00);
        tick(2);
        ce = 1'b0;
        mcam_host_model_i.wr(8'h74, 8'hff);
        ce = 1'b1;
        rd_chk("frozen mask", 8'h74, 8'h00);
        end_sim();
    end
endmodule : tb_monitor_config_alert_mask
